/* ddr_read_capture_resync.sv */
// Summary of operation
// R1 - high half taken rising, realigned falling strobe
// R2 - both halves valid only after falling strobe
// R3 - captured data resampled into system domain
// R4 - resample clock: system, shifted, or resample
// R5 - optional resample clock, optional extra stage
// R6 - strobe shifted by fixed delay, no control
// R7 - delay reference only from dedicated pin
// R8 - command register edge is selectable
// R9 - strobe released by host during reads
// R10 - resample edge inside round-trip safe window
// R11 - resample cycle zero after first falling
// R12 - even count rising edge, odd falling; code ignores resample_inv when resample_clk is selected
// R13 - fixed configurable latency from read issue
`timescale 1ns/10ps
`default_nettype none
`include "rdcap_consts.svh"
module ddr_read_capture_resync
  import rdcap_pkg::*;
(
  // system clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // optional resample clocks, shifted system clock
  input wire logic clk_shifted,
  input wire logic resample_clk,
  // configuration straps
  input wire logic [1:0] resample_sel,
  input wire logic resample_inv,
  input wire logic extra_stage,
  input wire logic cmd_on_fall,
  input wire logic [`LAT_W-1:0] read_latency,
  // command from controller
  input wire logic read_cmd,
  input wire logic write_cmd,
  // link: shifted strobe (link clock), data, strobe pin
  input wire logic dqs_shifted,
  input wire logic [`DQ_W-1:0] dq_in,
  output logic dqs_out,
  output logic dqs_oe_n,
  output logic cmd_read_out,
  // system side read data
  output var rd_pair_t rd_data,
  output logic rd_valid
);
  ////////////////////////////////////////////////////////////////////////
  // helpers shared by both crossing stages and the holding array
  function automatic logic toggled(input logic now_v, input logic prev_v);
    toggled = now_v ^ prev_v;
  endfunction : toggled

  function automatic logic [`CAP_IDX_W-1:0] idx_next(input logic [`CAP_IDX_W-1:0] idx);
    idx_next = idx + 1'b1;
  endfunction : idx_next

  ////////////////////////////////////////////////////////////////////////
  rd_pair_t cap_pair;
  logic cap_tgl;

  // the shift itself is in the strobe delay path and is fixed
  // its reference comes from a dedicated pin, so nothing here tunes it
  // capture is not reset: a reset while the toggle is high yields one stale pair
  strobe_capture i_strobe_capture ( // R6 R7
    .dqs_shifted(dqs_shifted),
    .dq_in(dq_in),
    .pair_out(cap_pair),
    .pair_tgl(cap_tgl)
  );

  ////////////////////////////////////////////////////////////////////////
  // resample clock choice; the inverted form serves an odd half-cycle count
  // straps are static: changing them while a pair crosses can glitch the clock
  wire logic pick_shifted = (resample_sel == `SEL_SHIFTED);
  wire logic pick_resample = (resample_sel == `SEL_RESAMPLE);
  wire logic base_clk = pick_shifted ? clk_shifted :
                        pick_resample ? resample_clk : mclk; // R4 R5
  wire logic inv_ok = ~pick_resample;
  wire logic rs_clk = base_clk ^ (resample_inv & inv_ok); // R4 R10 R12

  rd_pair_t rs_pair_q;
  logic rs_tgl_q1, rs_tgl_q2;
  // first flop of the toggle sync is read only by the second
  always_ff @(posedge rs_clk or negedge nrst) begin
    if (!nrst) begin
      rs_tgl_q1 <= 1'b0;
      rs_tgl_q2 <= 1'b0;
    end else begin
      rs_tgl_q1 <= cap_tgl; // R3
      rs_tgl_q2 <= rs_tgl_q1;
    end
  end
  logic rs_tgl_prev_q;
  // data is stable long before the toggle settles, so sampling on change is safe
  wire logic rs_new = toggled(rs_tgl_q2, rs_tgl_prev_q);
  always_ff @(posedge rs_clk or negedge nrst) begin
    if (!nrst) begin
      rs_tgl_prev_q <= 1'b0;
      rs_pair_q <= '0;
    end else begin
      rs_tgl_prev_q <= rs_tgl_q2;
      if (rs_new) rs_pair_q <= cap_pair; // R3 R10
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // hand-over into mclk; extra stage adds one more flop
  logic s_tgl_q1, s_tgl_q2, s_tgl_q3, s_tgl_prev_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_tgl_q1 <= 1'b0;
      s_tgl_q2 <= 1'b0;
      s_tgl_q3 <= 1'b0;
      s_tgl_prev_q <= 1'b0;
    end else begin
      s_tgl_q1 <= rs_tgl_prev_q;
      s_tgl_q2 <= s_tgl_q1;
      s_tgl_q3 <= s_tgl_q2; // R5
      s_tgl_prev_q <= extra_stage ? s_tgl_q3 : s_tgl_q2;
    end
  end
  wire logic s_tgl_now = extra_stage ? s_tgl_q3 : s_tgl_q2;
  wire logic s_new = toggled(s_tgl_now, s_tgl_prev_q); // R11

  ////////////////////////////////////////////////////////////////////////
  // small holding array so back-to-back beats survive the latency wait
  rd_pair_t hold_mem [`CAP_DEPTH];
  logic [`CAP_IDX_W-1:0] wr_idx_q, rd_idx_q;
  always_ff @(posedge mclk) begin
    if (s_new) hold_mem[wr_idx_q] <= rs_pair_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // latency counter started by the read command
  rs_state_t st_q, st_d;
  logic [`LAT_W-1:0] lat_q, lat_d;
  wire logic lat_done = (lat_q == '0);
  wire logic have_data = (wr_idx_q != rd_idx_q);
  wire logic deliver = (st_q == RS_SEND) & have_data;
  // true when the pair now leaving is the only one held
  wire logic last_pair = (wr_idx_q == idx_next(rd_idx_q));

  always_comb begin
    st_d = st_q;
    lat_d = lat_q;
    case (st_q)
      RS_IDLE: begin
        if (read_cmd) begin
          st_d = RS_WAIT;
          lat_d = read_latency; // R13
        end
      end
      RS_WAIT: begin
        if (lat_done) st_d = RS_SEND;
        else lat_d = lat_q - 1'b1; // R13
      end
      RS_SEND: begin
        // wait for the burst if it is still crossing; a lost burst parks us here
        if (deliver && last_pair && !s_new) st_d = RS_IDLE;
      end
      default: st_d = RS_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= RS_IDLE;
      lat_q <= `RESET_LAT;
    end else begin
      st_q <= st_d;
      lat_q <= lat_d;
    end
  end

  // write side advances on every crossed pair, read side on every delivery
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_idx_q <= '0;
      rd_idx_q <= '0;
    end else begin
      if (s_new) wr_idx_q <= idx_next(wr_idx_q);
      if (deliver) rd_idx_q <= idx_next(rd_idx_q);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= deliver; // R13
      if (deliver) rd_data <= hold_mem[rd_idx_q];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strobe pin: host drives only on write, released during reads
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dqs_oe_n <= 1'b1;
      dqs_out <= 1'b0;
    end else begin
      // a read wins over a write so the pin is never fought over
      dqs_oe_n <= ~write_cmd | read_cmd; // R9
      dqs_out <= write_cmd & ~dqs_out;
    end
  end

  // command register on either edge, chosen by strap
  logic cmd_rise_q, cmd_fall_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) cmd_rise_q <= 1'b0;
    else cmd_rise_q <= read_cmd;
  end
  // the falling flop retimes the rising capture, never the raw input that moves there
  always_ff @(negedge mclk or negedge nrst) begin
    if (!nrst) cmd_fall_q <= 1'b0;
    else cmd_fall_q <= cmd_rise_q;
  end
  // a final rising flop keeps the output registered whichever edge is chosen
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) cmd_read_out <= 1'b0;
    else cmd_read_out <= cmd_on_fall ? cmd_fall_q : cmd_rise_q; // R8
  end
endmodule : ddr_read_capture_resync
`default_nettype wire

/* rdcap_consts.svh */
`ifndef RDCAP_CONSTS_SVH
`define RDCAP_CONSTS_SVH
`define DQ_W 8
`define LAT_W 4
`define CAP_DEPTH 16
`define CAP_IDX_W 4
`define RESET_LAT 4'h3
`define CLK_PERIOD_PS 25000
`define STROBE_SHIFT_DEG 72
`define SEL_SYS 2'h0
`define SEL_SHIFTED 2'h1
`define SEL_RESAMPLE 2'h2
`endif

/* rdcap_pkg.sv */
package rdcap_pkg;
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } rd_pair_t;
  typedef enum logic [1:0] {
    RS_IDLE = 2'b00,
    RS_WAIT = 2'b01,
    RS_SEND = 2'b10
  } rs_state_t;
endpackage : rdcap_pkg

/* strobe_capture.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rdcap_consts.svh"
module strobe_capture
  import rdcap_pkg::*;
(
  // link side, on the shifted strobe
  input wire logic dqs_shifted,
  input wire logic [`DQ_W-1:0] dq_in,
  // captured pair, still in strobe domain
  output var rd_pair_t pair_out,
  output var logic pair_tgl
);
  logic [`DQ_W-1:0] hi_rise_q;
  logic tgl_q = 1'b0;

  // the strobe only toggles during a read burst, so no reset here
  always_ff @(posedge dqs_shifted) begin
    hi_rise_q <= dq_in; // R1
  end

  always_ff @(negedge dqs_shifted) begin
    pair_out.hi <= hi_rise_q; // R1
    pair_out.lo <= dq_in; // R2
    tgl_q <= ~tgl_q; // R2
  end
  assign pair_tgl = tgl_q;
endmodule : strobe_capture
`default_nettype wire

/* rdcap_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module rdcap_mon
  import rdcap_pkg::*;
(
  // watched ports
  input wire logic mclk,
  input wire logic nrst,
  input wire logic read_cmd,
  input wire logic write_cmd,
  input wire logic dqs_out,
  input wire logic dqs_oe_n,
  input wire logic cmd_read_out,
  input wire rd_pair_t rd_data,
  input wire logic rd_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_rel; !write_cmd || read_cmd |=> dqs_oe_n; endproperty
  a_rel: assert property (p_rel) else $error("strobe held");
  property p_drv; write_cmd && !read_cmd |=> !dqs_oe_n; endproperty
  a_drv: assert property (p_drv) else $error("strobe not driven");
  property p_tgl; write_cmd |=> dqs_out != $past(dqs_out); endproperty
  a_tgl: assert property (p_tgl) else $error("strobe stuck");
  property p_pls; rd_valid |=> !rd_valid; endproperty
  a_pls: assert property (p_pls) else $error("valid too long");
  property p_hold; !rd_valid |-> $stable(rd_data); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_early; read_cmd |=> !rd_valid [*2]; endproperty
  a_early: assert property (p_early) else $error("data early");
  property p_cmd; read_cmd |-> ##[1:3] cmd_read_out; endproperty
  a_cmd: assert property (p_cmd) else $error("no command");
  property p_why; $rose(cmd_read_out) |-> $past(read_cmd) || $past(read_cmd, 2); endproperty
  a_why: assert property (p_why) else $error("stray command");
  c_val: cover property (rd_valid);
  c_cmd: cover property (cmd_read_out);
  c_wr: cover property (!dqs_oe_n);
endmodule : rdcap_mon
bind ddr_read_capture_resync rdcap_mon i_mon (.mclk, .nrst, .read_cmd, .write_cmd, .dqs_out,
  .dqs_oe_n, .cmd_read_out, .rd_data, .rd_valid);
`default_nettype wire

/* ddr_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ddr_mem_model
  import rdcap_pkg::*;
(
  // request
  input wire logic go,
  input wire rd_pair_t pair,
  // link
  output var logic dqs_shifted,
  output var logic [7:0] dq_in
);
  initial begin
    dqs_shifted = 1'b0;
    dq_in = 8'h00;
  end
  // one pair per burst keeps the crossing spacing; strobe parked low
  always @(posedge go) begin
    #3 dq_in = pair.hi;
    #7.5 dqs_shifted = 1'b1;
    #7.5 dq_in = pair.lo;
    #7.5 dqs_shifted = 1'b0;
    #7.5 dq_in = ~pair.lo;
  end
endmodule : ddr_mem_model
`default_nettype wire

/* testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench
  import rdcap_pkg::*;
;
  logic mclk = 0, nrst = 0, read_cmd = 0, write_cmd = 0, go = 0, inv = 0, ex = 0, fall = 0;
  logic [1:0] sel = 0;
  logic [3:0] lat = 4'h3;
  logic dqs_shifted, dqs_out, dqs_oe_n, cmd_read_out, rd_valid;
  logic [7:0] dq_in;
  rd_pair_t pair, rd_data;
  wire logic clk_shifted, resample_clk;
  int num_errors = 0, cmp_count = 0;
  assign #6 clk_shifted = mclk;
  assign #11 resample_clk = mclk;
  always #12.5 mclk = ~mclk;
  ddr_read_capture_resync i_ddr_read_capture_resync (.mclk(mclk), .nrst(nrst),
    .clk_shifted(clk_shifted), .resample_clk(resample_clk), .resample_sel(sel),
    .resample_inv(inv), .extra_stage(ex), .cmd_on_fall(fall), .read_latency(lat),
    .read_cmd(read_cmd), .write_cmd(write_cmd), .dqs_shifted(dqs_shifted), .dq_in(dq_in),
    .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n), .cmd_read_out(cmd_read_out), .rd_data(rd_data),
    .rd_valid(rd_valid));
  ddr_mem_model i_ddr_mem_model (.go(go), .pair(pair), .dqs_shifted(dqs_shifted),
    .dq_in(dq_in));
  task automatic end_sim;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic read_pair(input logic [8:0] cfg, input rd_pair_t p);
    int n;
    n = 1;
    {sel, inv, ex, fall, lat} = cfg;
    pair = p;
    @(negedge mclk);
    read_cmd = 1;
    @(negedge mclk);
    read_cmd = 0;
    go = 1;
    @(negedge mclk);
    `CHK("cmd out", 1'b1, cmd_read_out)
    while (rd_valid !== 1'b1 && n < 80) begin
      @(negedge mclk);
      n++;
    end
    go = 0;
    `CHK("valid", 1'b1, rd_valid)
    `CHK("pair", p, rd_data)
    `CHK("latency", 1'b1, n >= lat + 2)
    @(negedge mclk);
    `CHK("pulse", 1'b0, rd_valid)
    // straps are static: drain fully before the next setting
    repeat (lat + 4) @(negedge mclk);
  endtask : read_pair
  task automatic t_reset;
    repeat (10) @(negedge mclk);
    `CHK("oe_n rst", 1'b1, dqs_oe_n)
    `CHK("valid rst", 1'b0, rd_valid)
    nrst = 1;
    $display("t_reset done");
  endtask : t_reset
  task automatic t_write;
    write_cmd = 1;
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk);
      `CHK("dqs wr", ~i[0], dqs_out)
    end
    `CHK("oe_n wr", 1'b0, dqs_oe_n)
    write_cmd = 0;
    repeat (2) @(negedge mclk);
    `CHK("oe_n rd", 1'b1, dqs_oe_n)
    $display("t_write done");
  endtask : t_write
  task automatic t_sources;
    read_pair({2'h0, 3'h0, 4'h3}, 16'ha55a);
    read_pair({2'h0, 3'h4, 4'h3}, 16'h0ff0);
    read_pair({2'h1, 3'h4, 4'h3}, 16'h3cc3);
    read_pair({2'h2, 3'h0, 4'h3}, 16'h1234);
    $display("t_sources done");
  endtask : t_sources
  task automatic t_options;
    read_pair({2'h0, 3'h2, 4'h6}, 16'hc0de);
    read_pair({2'h1, 3'h1, 4'hf}, 16'h8001);
    $display("t_options done");
  endtask : t_options
  initial begin
    t_reset;
    t_write;
    t_sources;
    t_options;
    end_sim;
  end
  initial begin
    #60000;
    num_errors++;
    end_sim;
  end
endmodule : testbench
`default_nettype wire
